// >>> verif/psl_link_partner.sv
`default_nettype none
module psl_link_partner #(
  parameter int LAG = 3
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic dut_oe,
  input  wire logic stubborn,
  output logic      partner_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // ==========================================================
  // partner wants the clock while the switch does; it lets go
  // LAG+1 cycles later, or never when told to be stubborn
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      partner_oe <= 1'b1;
      cnt        <= 0;
    end else if (dut_oe) begin
      partner_oe <= 1'b1;
      cnt        <= 0;
    end else if (!stubborn && cnt >= LAG) begin
      partner_oe <= 1'b0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/ptm_cap_and_l1_substate_ctrl_bench.sv
`default_nettype none
module ptm_cap_and_l1_substate_ctrl_bench;
  import psl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hready;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, d;
  logic        hreadyout, hresp, up, l1, aspm, pin_n, out_n, oe, p_oe;
  logic        l11, resume, tm_en, tm_root, stub;
  int          err_count, n_checks, seed, n;
  logic [31:0] model [8];
  logic [11:0] addr [8] = '{PSL_OFF_TM_HDR, PSL_OFF_TM_CAP, PSL_OFF_TM_CTRL,
    PSL_OFF_CRQ_WAIT, PSL_OFF_SUB_DLY, PSL_OFF_GEN_A, PSL_OFF_GEN_B,
    PSL_OFF_GEN_C};
  // pull-up on the shared open-drain wire
  assign pin_n = (oe || p_oe) ? out_n : 1'b1;
  assign hready = hreadyout;
  psl_regs u_psl_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .upstream_port(up),
    .link_l1_entered(l1), .link_aspm(aspm), .clock_request_n_in(pin_n),
    .clock_request_n_out(out_n), .clock_request_n_oe(oe),
    .substate_l11(l11), .substate_resume(resume),
    .time_meas_enable(tm_en), .time_meas_root(tm_root));
  psl_link_partner u_psl_link_partner (.hclk(hclk), .hresetn(hresetn),
    .dut_oe(oe), .stubborn(stub), .partner_oe(p_oe));
  // ==========================================================
  function automatic logic [31:0] rst_val(input int i);
    case (i)
      0: return 32'h0001001F;
      1: return 32'h00000007;
      3: return 32'h00000FFF;
      4: return 32'h01FF01FF;
      7: return 32'h000FFFFF;
      default: return 32'h00000000;
    endcase
  endfunction
  function automatic logic [31:0] wmask(input int i);
    case (i)
      0, 1: return 32'h00000000;
      2: return 32'h0000FF03;
      3: return 32'h000FFFFF;
      default: return 32'hFFFFFFFF;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic link_run(input logic s, input logic a);
    @(posedge hclk);
    stub <= s; aspm <= a; l1 <= 1'b1;
    n = 0;
    do begin @(negedge hclk); n++; end while (oe !== 1'b0 && n < 100);
    chk("release delay", 1, n >= (a ? 5 : 3) && n <= (a ? 9 : 7));
    n = 0;
    do begin @(negedge hclk); n++; end
    while (l11 !== 1'b1 && resume !== 1'b1 && n < 100);
    chk("l1.1 entered", !s, l11);
    chk("pin released", s, oe);
    if (s) chk("wait honoured", 1, n >= 20 && n <= 30);
    @(posedge hclk);
    l1 <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("back in l0", 3'b100, {oe, l11, resume});
    $display("link test stubborn=%0b aspm=%0b done", s, a);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    end_of_test();
  end
  initial begin
    seed = 32'hE5E6;
    hresetn = 1'b0; hsel = 1'b0; haddr = 12'h000; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; up = 1'b1;
    l1 = 1'b0; aspm = 1'b0; stub = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      model[i] = rst_val(i);
      xfer(1'b0, addr[i], 32'h0, rd);
      chk("reset value", model[i], rd);
    end
    $display("reset value test done");
    // random writes, then corners: all ones and all zeros
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 8; i++) begin
        d = (k == 4) ? 32'hFFFFFFFF : (k == 5) ? 32'h0 : $random(seed);
        xfer(1'b1, addr[i], d, rd);
        model[i] = (model[i] & ~wmask(i)) | (d & wmask(i));
        xfer(1'b0, addr[i], 32'h0, rd);
        chk("read back", model[i], rd);
      end
      chk("enable out", model[2][0], tm_en);
      chk("root out", &model[2][1:0], tm_root);
    end
    xfer(1'b1, 12'h400, $random(seed), rd);
    xfer(1'b0, 12'h400, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    up <= 1'b0;
    xfer(1'b0, PSL_OFF_TM_HDR, 32'h0, rd);
    chk("downstream hdr", 32'h0, rd);
    up <= 1'b1;
    $display("register test done");
    xfer(1'b1, PSL_OFF_CRQ_WAIT, 32'h0000000A, rd);
    xfer(1'b1, PSL_OFF_SUB_DLY, 32'h00050003, rd);
    xfer(1'b1, PSL_OFF_PM_CTRL, 32'h00000001, rd);
    for (int j = 0; j < 4; j++) link_run(j[1], j[0]);
    xfer(1'b0, PSL_OFF_PM_STAT, 32'h0, rd);
    chk("timeout seen", 32'h00000008, rd);
    xfer(1'b1, PSL_OFF_PM_STAT, 32'h00000008, rd);
    xfer(1'b0, PSL_OFF_PM_STAT, 32'h0, rd);
    chk("timeout clear", 32'h00000000, rd);
    end_of_test();
  end
endmodule
`default_nettype wire

// >>> verilog/psl_pkg.sv
`default_nettype none
package psl_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] PSL_OFF_TM_HDR   = 12'h260;
  localparam logic [11:0] PSL_OFF_TM_CAP   = 12'h264;
  localparam logic [11:0] PSL_OFF_TM_CTRL  = 12'h268;
  localparam logic [11:0] PSL_OFF_CRQ_WAIT = 12'h300;
  localparam logic [11:0] PSL_OFF_SUB_DLY  = 12'h304;
  localparam logic [11:0] PSL_OFF_GEN_A    = 12'h308;
  localparam logic [11:0] PSL_OFF_GEN_B    = 12'h30C;
  localparam logic [11:0] PSL_OFF_GEN_C    = 12'h310;
  localparam logic [11:0] PSL_OFF_PM_CTRL  = 12'h314;
  localparam logic [11:0] PSL_OFF_PM_STAT  = 12'h31C;
  // ==========================================================
  // fixed capability content
  localparam logic [15:0] PSL_TM_CAP_ID    = 16'h001F;
  localparam logic [3:0]  PSL_TM_CAP_VER   = 4'h1;
  localparam logic [11:0] PSL_TM_NEXT      = 12'h000;
  localparam logic [2:0]  PSL_TM_ROLES     = 3'h7;
  localparam logic [7:0]  PSL_TM_LCL_GRAN  = 8'h00;
  // ==========================================================
  // reset values and field layout
  localparam logic [19:0] PSL_CRQ_WAIT_RST = 20'h00FFF;
  localparam logic [15:0] PSL_SUB_DLY_RST  = 16'h01FF;
  localparam logic [31:0] PSL_GEN_C_RST    = 32'h000FFFFF;
  localparam logic [31:0] PSL_CTRL_WMASK   = 32'h0000FF03;
  localparam int          PSL_WAIT_UNIT_NS = 10;
  localparam int          PSL_DLY_UNIT_NS  = 4;
  localparam int          PSL_CLK_NS       = 5;
  localparam int          PSL_WAIT_CYC     = PSL_WAIT_UNIT_NS / PSL_CLK_NS;
  // 4 ns unit is shorter than one cycle: one count takes one cycle
  localparam int          PSL_DLY_CYC      = 1;
  // ==========================================================
  typedef enum logic [2:0] {
    PSL_L0       = 3'b000,
    PSL_L1       = 3'b001,
    PSL_L11_WAIT = 3'b011,
    PSL_L11      = 3'b010,
    PSL_RESUME   = 3'b110
  } psl_state_t;
endpackage
`default_nettype wire

// >>> verilog/psl_regs.sv
// The AHB-Lite slave port was left to the implementer.
`default_nettype none
module psl_regs
  import psl_pkg::*;
#(
  parameter int TIMER_W = 24
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        upstream_port,
  input  wire logic        link_l1_entered,
  input  wire logic        link_aspm,
  input  wire logic        clock_request_n_in,
  output logic             clock_request_n_out,
  output logic             clock_request_n_oe,
  output logic             substate_l11,
  output logic             substate_resume,
  output logic             time_meas_enable,
  output logic             time_meas_root
);
  // the 20-bit wait field times two cycles per count needs 21 bits
  if (TIMER_W < 21) begin : g_timer_w_bad
    $error("TIMER_W too small for wait field");
  end

  // ==========================================================
  // bus slave
  logic        wr_pend;
  logic [11:0] wr_addr;
  logic [7:0]  time_meas_gran;
  logic [19:0] clock_request_wait_time;
  logic [15:0] sw_pm_substate_delay;
  logic [15:0] active_pm_substate_delay;
  logic [31:0] general_control_word_a;
  logic [31:0] general_control_word_b;
  logic [31:0] general_control_word_c;
  logic        substate_en;
  logic        crq_sync1;
  logic        crq_sync2;
  logic        timeout_seen;
  psl_state_t  state;
  psl_state_t  next_state;
  logic [TIMER_W-1:0] timer;
  logic        take;

  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      wr_pend <= take && hwrite;
      wr_addr <= {haddr[11:2], 2'b00};
    end
  end

  // ==========================================================
  // writable registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      time_meas_enable         <= 1'b0;
      time_meas_root           <= 1'b0;
      time_meas_gran           <= 8'h00;
      clock_request_wait_time  <= PSL_CRQ_WAIT_RST;
      sw_pm_substate_delay     <= PSL_SUB_DLY_RST;
      active_pm_substate_delay <= PSL_SUB_DLY_RST;
      general_control_word_a   <= 32'h00000000;
      general_control_word_b   <= 32'h00000000;
      general_control_word_c   <= PSL_GEN_C_RST;
      substate_en              <= 1'b0;
    end else if (wr_pend) begin
      unique case (wr_addr)
        PSL_OFF_TM_CTRL: begin
          // the capability exists on the upstream port only
          if (upstream_port) begin
            time_meas_enable <= hwdata[0];
            time_meas_root   <= hwdata[1];
            time_meas_gran   <= hwdata[15:8];
          end
        end
        PSL_OFF_CRQ_WAIT: clock_request_wait_time <= hwdata[19:0];
        PSL_OFF_SUB_DLY: begin
          sw_pm_substate_delay     <= hwdata[15:0];
          active_pm_substate_delay <= hwdata[31:16];
        end
        PSL_OFF_GEN_A:   general_control_word_a <= hwdata;
        PSL_OFF_GEN_B:   general_control_word_b <= hwdata;
        PSL_OFF_GEN_C:   general_control_word_c <= hwdata;
        PSL_OFF_PM_CTRL: substate_en <= hwdata[0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // read data, registered in the address phase
  // decoding the address phase keeps the slave free of wait states
  logic [31:0] rd_mux;
  logic        tm_root_eff;
  assign tm_root_eff = time_meas_enable && time_meas_root;

  always_comb begin
    rd_mux = 32'h00000000;
    unique case ({haddr[11:2], 2'b00})
      PSL_OFF_TM_HDR:
        if (upstream_port)
          rd_mux = {PSL_TM_NEXT, PSL_TM_CAP_VER, PSL_TM_CAP_ID};
      PSL_OFF_TM_CAP:
        if (upstream_port)
          rd_mux = {16'h0000, PSL_TM_LCL_GRAN, 5'h00, PSL_TM_ROLES};
      PSL_OFF_TM_CTRL:
        if (upstream_port)
          rd_mux = {16'h0000, time_meas_gran, 6'h00, time_meas_root,
                    time_meas_enable};
      PSL_OFF_CRQ_WAIT: rd_mux = {12'h000, clock_request_wait_time};
      PSL_OFF_SUB_DLY:
        rd_mux = {active_pm_substate_delay, sw_pm_substate_delay};
      PSL_OFF_GEN_A:   rd_mux = general_control_word_a;
      PSL_OFF_GEN_B:   rd_mux = general_control_word_b;
      PSL_OFF_GEN_C:   rd_mux = general_control_word_c;
      PSL_OFF_PM_CTRL: rd_mux = {31'h00000000, substate_en};
      PSL_OFF_PM_STAT:
        rd_mux = {27'h0000000, tm_root_eff, timeout_seen, state};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // ==========================================================
  // clock-request line and L1.1 sequencing
  // reset level 0 matches the pin held low by our own request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crq_sync1 <= 1'b0;
      crq_sync2 <= 1'b0;
    end else begin
      crq_sync1 <= clock_request_n_in;
      crq_sync2 <= crq_sync1;
    end
  end

  logic [TIMER_W-1:0] entry_limit;
  logic [TIMER_W-1:0] wait_limit;
  always_comb begin
    entry_limit = link_aspm
      ? TIMER_W'(active_pm_substate_delay) * TIMER_W'(PSL_DLY_CYC)
      : TIMER_W'(sw_pm_substate_delay) * TIMER_W'(PSL_DLY_CYC);
    wait_limit = TIMER_W'(clock_request_wait_time) * TIMER_W'(PSL_WAIT_CYC);
  end

  always_comb begin
    next_state = state;
    unique case (state)
      PSL_L0: if (link_l1_entered && substate_en) next_state = PSL_L1;
      PSL_L1:
        if (!link_l1_entered) next_state = PSL_L0;
        else if (timer >= entry_limit) next_state = PSL_L11_WAIT;
      PSL_L11_WAIT:
        if (crq_sync2) next_state = PSL_L11;
        else if (timer >= wait_limit) next_state = PSL_RESUME;
      PSL_L11: if (!crq_sync2 || !link_l1_entered) next_state = PSL_RESUME;
      PSL_RESUME: if (!link_l1_entered) next_state = PSL_L0;
      default: next_state = PSL_L0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= PSL_L0;
      timer <= '0;
    end else begin
      state <= next_state;
      // saturates so that a link parked in one state never wraps
      if (next_state != state) timer <= '0;
      else if (timer != '1) timer <= timer + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_seen <= 1'b0;
    // a timeout wins over a write-one clear in the same cycle
    end else if (state == PSL_L11_WAIT && next_state == PSL_RESUME) begin
      timeout_seen <= 1'b1;
    end else if (wr_pend && wr_addr == PSL_OFF_PM_STAT && hwdata[3]) begin
      timeout_seen <= 1'b0;
    end
  end

  // pin released (oe low) in L1.1 and while waiting for the partner
  assign clock_request_n_out = 1'b0;
  assign clock_request_n_oe  = !(state == PSL_L11_WAIT ||
                                 state == PSL_L11);
  assign substate_l11        = (state == PSL_L11);
  assign substate_resume     = (state == PSL_RESUME);

  // ==========================================================
  // checks
  release_now_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(state == PSL_L11_WAIT) |-> !clock_request_n_oe)
    else $error("clock request not released on L1.1 entry");
  timeout_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_L11_WAIT && !crq_sync2 && timer >= wait_limit)
      |=> clock_request_n_oe && state == PSL_RESUME)
    else $error("wait timeout did not reassert clock request");
  wait_min_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_L11_WAIT && next_state == PSL_RESUME)
      |-> timer >= wait_limit)
    else $error("resume before wait time expired");
  entry_dly_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_L1 && next_state == PSL_L11_WAIT)
      |-> timer >= entry_limit)
    else $error("L1.1 entered before delay");
  root_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && upstream_port && wr_addr == PSL_OFF_TM_CTRL && !hwdata[0])
      |=> !tm_root_eff)
    else $error("root without enable");
  hdr_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && upstream_port && haddr == PSL_OFF_TM_HDR)
      |=> hrdata == 32'h0001001F)
    else $error("capability header wrong");
  cap_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && upstream_port && haddr == PSL_OFF_TM_CAP)
      |=> hrdata == 32'h00000007)
    else $error("capability word wrong");
  ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && upstream_port && wr_addr == PSL_OFF_TM_CTRL)
      |=> time_meas_enable == $past(hwdata[0]))
    else $error("enable bit not written");
  rsvd_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && haddr == PSL_OFF_CRQ_WAIT)
      |=> hrdata[31:20] == 12'h000)
    else $error("reserved bits nonzero");
  gen_c_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && wr_addr == PSL_OFF_GEN_C)
      |=> general_control_word_c == $past(hwdata))
    else $error("word c not written");
  map_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && !upstream_port && haddr == PSL_OFF_TM_CTRL)
      |=> hrdata == 32'h00000000)
    else $error("capability visible on downstream port");


  // ==========================================================
  // register write and read checks
  root_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && upstream_port && wr_addr == PSL_OFF_TM_CTRL)
      |=> time_meas_root == $past(hwdata[1]))
    else $error("root select not written");
  gran_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && upstream_port && wr_addr == PSL_OFF_TM_CTRL)
      |=> time_meas_gran == $past(hwdata[15:8]))
    else $error("granularity not written");
  ctrl_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && !upstream_port && wr_addr == PSL_OFF_TM_CTRL)
      |=> $stable(time_meas_enable) && $stable(time_meas_root))
    else $error("control written on downstream port");
  wait_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && wr_addr == PSL_OFF_CRQ_WAIT)
      |=> clock_request_wait_time == $past(hwdata[19:0]))
    else $error("wait time not written");
  dly_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_pend && wr_addr == PSL_OFF_SUB_DLY)
      |=> {active_pm_substate_delay, sw_pm_substate_delay}
          == $past(hwdata))
    else $error("entry delays not written");
  hdr_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && !upstream_port && haddr == PSL_OFF_TM_HDR)
      |=> hrdata == 32'h00000000)
    else $error("header visible on downstream port");
  ctrl_rsvd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && upstream_port && haddr == PSL_OFF_TM_CTRL)
      |=> hrdata[31:16] == 16'h0000 && hrdata[7:2] == 6'h00)
    else $error("control reserved bits nonzero");
  rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(take && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  // ==========================================================
  // substate sequencing checks
  sub_enter_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_L0 && link_l1_entered && substate_en)
      |=> state == PSL_L1)
    else $error("L1 not followed");
  no_enter_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_L0 && !substate_en) |=> state == PSL_L0)
    else $error("substate sequence ran while disabled");
  l1_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_L1 && !link_l1_entered)
      |=> state == PSL_L0 && clock_request_n_oe)
    else $error("L1 exit not followed");
  entry_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_L1 && link_l1_entered && timer >= entry_limit)
      |=> state == PSL_L11_WAIT && !clock_request_n_oe)
    else $error("L1.1 entry late");
  partner_rel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_L11_WAIT && crq_sync2)
      |=> state == PSL_L11 && !clock_request_n_oe)
    else $error("partner release not honoured");
  l11_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_L11 && !crq_sync2)
      |=> state == PSL_RESUME && clock_request_n_oe)
    else $error("clock request not reasserted in L1.1");
  resume_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_RESUME && link_l1_entered)
      |=> state == PSL_RESUME && clock_request_n_oe)
    else $error("resume left early");
  resume_l0_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_RESUME && !link_l1_entered) |=> state == PSL_L0)
    else $error("resume did not reach L0");
  timer_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (next_state != state) |=> timer == '0)
    else $error("timer not cleared on state change");
  timer_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (next_state == state && timer != '1)
      |=> timer == $past(timer) + 1'b1)
    else $error("timer did not count");
  sticky_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == PSL_L11_WAIT && next_state == PSL_RESUME)
      |=> timeout_seen)
    else $error("timeout not recorded");
  sticky_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (timeout_seen && !(wr_pend && wr_addr == PSL_OFF_PM_STAT && hwdata[3]))
      |=> timeout_seen)
    else $error("timeout flag lost");

  resume_c: cover property (@(posedge hclk) disable iff (!hresetn)
    state == PSL_RESUME ##1 state == PSL_L0);
  clear_c: cover property (@(posedge hclk) disable iff (!hresetn)
    timeout_seen ##1 !timeout_seen);
  enter_l11_c: cover property (@(posedge hclk) disable iff (!hresetn)
    state == PSL_L11_WAIT ##[1:50] state == PSL_L11);
  timeout_c: cover property (@(posedge hclk) disable iff (!hresetn)
    state == PSL_L11_WAIT ##1 state == PSL_RESUME);
  root_c: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(tm_root_eff));
endmodule
`default_nettype wire
